// file: tpg_pkg.sv
package tpg_pkg;

  // ==========================================================
  // Direct register offsets
  localparam logic [7:0] REG_SELECT_CONTROL = 8'h64;
  localparam logic [7:0] REG_CONFIG = 8'h65;
  localparam logic [7:0] REG_INDIRECT_ADDRESS = 8'h66;
  localparam logic [7:0] REG_INDIRECT_DATA = 8'h67;

  // ==========================================================
  // pattern_select_control fields
  localparam int SEL_PATTERN_LSB = 0;
  localparam int SEL_PATTERN_W = 5;
  localparam int SEL_INVERT_BIT = 5;
  localparam int SEL_CHECKER_CUSTOM_BIT = 6;
  localparam int SEL_ORDER_REVERSE_BIT = 7;
  localparam logic [7:0] SELECT_CONTROL_RESET = 8'h01;

  // ==========================================================
  // pattern_config fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_GLOBAL_INVERT_BIT = 1;
  localparam int CFG_COLOR18_BIT = 2;
  localparam int CFG_TIMING_LSB = 3;
  localparam int CFG_SCROLL_BIT = 5;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  typedef enum logic [1:0] {
    TPG_TIMING_EXTERNAL = 2'b00,
    TPG_TIMING_INTERNAL = 2'b01,
    TPG_TIMING_INT_EXTCLK = 2'b10
  } tpg_timing_t;

  // ==========================================================
  // Indirect register indices
  localparam int IND_RED = 0;
  localparam int IND_GREEN = 1;
  localparam int IND_BLUE = 2;
  localparam int IND_SCROLL_CTRL = 3;
  localparam int IND_SCROLL_FRAMES = 4;
  localparam int IND_ORDER_FIRST = 5;
  localparam int IND_HACT_LO = 13;
  localparam int IND_HTOT_LO = 15;
  localparam int IND_VACT_LO = 17;
  localparam int IND_VTOT_LO = 19;
  localparam int IND_HSYNC_W = 21;
  localparam int IND_VSYNC_W = 22;
  localparam int IND_OSC_DIV = 23;
  localparam int IND_RW_COUNT = 24;
  localparam logic [7:0] IND_WIDTH_LO = 8'h18;
  localparam logic [7:0] IND_WIDTH_HI = 8'h19;
  localparam logic [7:0] IND_HEIGHT_LO = 8'h1A;
  localparam logic [7:0] IND_HEIGHT_HI = 8'h1B;
  localparam logic [7:0] IND_STATUS = 8'h1C;

  // 640x480 style defaults, slots 0..15 showing patterns 1..16, 60 frames per step
  localparam logic [7:0] IND_RESET [IND_RW_COUNT] = '{
    8'hFF, 8'h00, 8'h00, 8'h0F, 8'h3C,
    8'h10, 8'h32, 8'h54, 8'h76, 8'h98, 8'hBA, 8'hDC, 8'hFE,
    8'h80, 8'h02, 8'h20, 8'h03, 8'hE0, 8'h01, 8'h0D, 8'h02,
    8'h60, 8'h02, 8'h01
  };

  // ==========================================================
  // Geometry and timing
  localparam int CW = 12;
  localparam int RAMP_BITS = 8;
  localparam int CHECKER_BIT = 5;
  localparam logic [4:0] PAT_WHITE = 5'h01;
  localparam logic [4:0] PAT_HRAMP_FIRST = 5'h06;
  localparam logic [4:0] PAT_VRAMP_FIRST = 5'h0A;
  localparam logic [4:0] PAT_CUSTOM = 5'h0E;
  localparam logic [4:0] PAT_CHECKER = 5'h0F;
  localparam logic [4:0] PAT_FOUR_COLOUR = 5'h10;
  localparam logic [4:0] PAT_BARS = 5'h11;
  localparam logic [7:0] COLOR18_MASK = 8'hFC;
  localparam int SYS_CLK_MHZ = 40;
  localparam int CLK_LOSS_NS = 1000;
  localparam int CLK_LOSS_CYCLES = (CLK_LOSS_NS * SYS_CLK_MHZ + 999) / 1000;

endpackage

// file: tpg_top.sv
module tpg_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_power_down,
  input wire logic i_pix_stb,
  input wire logic i_ext_clk,
  input wire logic i_de,
  input wire logic i_hs,
  input wire logic i_vs,
  input wire logic [7:0] i_red,
  input wire logic [7:0] i_green,
  input wire logic [7:0] i_blue,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_de,
  output logic o_hs,
  output logic o_vs,
  output logic [7:0] o_red,
  output logic [7:0] o_green,
  output logic [7:0] o_blue
);

  localparam int CW = tpg_pkg::CW;
  localparam int PIN_W = 29;

  // ==========================================================
  // Functions
  function automatic logic [3:0] ramp_shift(input logic [CW-1:0] w);
    logic [CW-1:0] m;
    logic [3:0] s;
    m = w - 1'b1;
    s = 4'h0;
    for (int i = tpg_pkg::RAMP_BITS; i < CW; i++) begin
      if (m[i]) begin
        s = 4'(i - tpg_pkg::RAMP_BITS + 1);
      end
    end
    return s;
  endfunction

  function automatic logic [23:0] prim(input logic [2:0] rgb_on, input logic [7:0] lvl);
    return {rgb_on[2] ? lvl : 8'h00, rgb_on[1] ? lvl : 8'h00, rgb_on[0] ? lvl : 8'h00};
  endfunction

  // Primary mask for solid and ramp groups: white, red, green, blue
  function automatic logic [2:0] group_mask(input logic [1:0] k);
    logic [2:0] m;
    unique case (k)
      2'h0: m = 3'b111;
      2'h1: m = 3'b100;
      2'h2: m = 3'b010;
      2'h3: m = 3'b001;
    endcase
    return m;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg;
  logic ext_clk_prev_reg;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      ext_clk_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {i_power_down, i_ext_clk, i_de, i_hs, i_vs, i_red, i_green, i_blue};
      pin_sync_reg <= pin_meta_reg;
      ext_clk_prev_reg <= pin_sync_reg[27];
    end
  end
  logic pd_s, ext_clk_s, de_s, hs_s, vs_s;
  logic [23:0] rgb_s;
  assign {pd_s, ext_clk_s, de_s, hs_s, vs_s, rgb_s} = pin_sync_reg;

  // ==========================================================
  // Registers
  logic [7:0] sel_reg, sel_next, cfg_reg, cfg_next, idx_reg, idx_next;
  logic [7:0] bank_reg [tpg_pkg::IND_RW_COUNT];
  logic [7:0] bank_next [tpg_pkg::IND_RW_COUNT];
  logic [7:0] rdata_reg, rdata_next;
  logic [CW-1:0] width_reg, height_reg;
  logic clk_present_reg;
  logic [4:0] pattern;
  tpg_pkg::tpg_timing_t timing_mode;

  assign timing_mode = tpg_pkg::tpg_timing_t'(cfg_reg[tpg_pkg::CFG_TIMING_LSB +: 2]);

  always_comb begin
    sel_next = sel_reg;
    cfg_next = cfg_reg;
    idx_next = idx_reg;
    bank_next = bank_reg;
    rdata_next = rdata_reg;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        tpg_pkg::REG_SELECT_CONTROL: sel_next = i_reg_wdata;
        tpg_pkg::REG_CONFIG: cfg_next = i_reg_wdata;
        tpg_pkg::REG_INDIRECT_ADDRESS: idx_next = i_reg_wdata;
        tpg_pkg::REG_INDIRECT_DATA: begin
          if (idx_reg < 8'(tpg_pkg::IND_RW_COUNT)) begin
            bank_next[idx_reg[4:0]] = i_reg_wdata;
          end
        end
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        tpg_pkg::REG_SELECT_CONTROL: rdata_next = sel_reg;
        tpg_pkg::REG_CONFIG: rdata_next = cfg_reg;
        tpg_pkg::REG_INDIRECT_ADDRESS: rdata_next = idx_reg;
        tpg_pkg::REG_INDIRECT_DATA: begin
          if (idx_reg < 8'(tpg_pkg::IND_RW_COUNT)) begin
            rdata_next = bank_reg[idx_reg[4:0]];
          end else begin
            unique case (idx_reg)
              tpg_pkg::IND_WIDTH_LO: rdata_next = width_reg[7:0];
              tpg_pkg::IND_WIDTH_HI: rdata_next = 8'(width_reg[CW-1:8]);
              tpg_pkg::IND_HEIGHT_LO: rdata_next = height_reg[7:0];
              tpg_pkg::IND_HEIGHT_HI: rdata_next = 8'(height_reg[CW-1:8]);
              tpg_pkg::IND_STATUS: rdata_next = {2'b00, clk_present_reg, pattern};
              default: rdata_next = 8'h00;
            endcase
          end
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_reg <= tpg_pkg::SELECT_CONTROL_RESET;
      cfg_reg <= tpg_pkg::CONFIG_RESET;
      idx_reg <= 8'h00;
      bank_reg <= tpg_pkg::IND_RESET;
      rdata_reg <= 8'h00;
    end else begin
      sel_reg <= sel_next;
      cfg_reg <= cfg_next;
      idx_reg <= idx_next;
      bank_reg <= bank_next;
      rdata_reg <= rdata_next;
    end
  end

  logic [CW-1:0] h_act, h_tot, v_act, v_tot;
  assign h_act = {bank_reg[tpg_pkg::IND_HACT_LO + 1][CW-9:0], bank_reg[tpg_pkg::IND_HACT_LO]};
  assign h_tot = {bank_reg[tpg_pkg::IND_HTOT_LO + 1][CW-9:0], bank_reg[tpg_pkg::IND_HTOT_LO]};
  assign v_act = {bank_reg[tpg_pkg::IND_VACT_LO + 1][CW-9:0], bank_reg[tpg_pkg::IND_VACT_LO]};
  assign v_tot = {bank_reg[tpg_pkg::IND_VTOT_LO + 1][CW-9:0], bank_reg[tpg_pkg::IND_VTOT_LO]};

  // ==========================================================
  // Pixel clock selection
  logic [7:0] loss_cnt_reg, loss_cnt_next, osc_cnt_reg, osc_cnt_next;
  logic clk_present_next, osc_stb, ext_stb, use_internal, pix_en;
  always_comb begin
    loss_cnt_next = loss_cnt_reg;
    clk_present_next = clk_present_reg;
    if (i_pix_stb) begin
      loss_cnt_next = 8'h00;
      clk_present_next = 1'b1;
    end else if (loss_cnt_reg >= 8'(tpg_pkg::CLK_LOSS_CYCLES)) begin
      clk_present_next = 1'b0;
    end else begin
      loss_cnt_next = loss_cnt_reg + 8'h01;
    end
    osc_stb = (osc_cnt_reg >= bank_reg[tpg_pkg::IND_OSC_DIV]);
    osc_cnt_next = osc_stb ? 8'h00 : osc_cnt_reg + 8'h01;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      loss_cnt_reg <= 8'h00;
      clk_present_reg <= 1'b0;
      osc_cnt_reg <= 8'h00;
    end else begin
      loss_cnt_reg <= loss_cnt_next;
      clk_present_reg <= clk_present_next;
      osc_cnt_reg <= osc_cnt_next;
    end
  end

  assign ext_stb = ext_clk_s & ~ext_clk_prev_reg;
  // One pixel step per selected clock
  always_comb begin
    unique case (timing_mode)
      tpg_pkg::TPG_TIMING_EXTERNAL: begin
        // Oscillator takes over when no input clock
        use_internal = ~clk_present_reg;
        pix_en = clk_present_reg ? i_pix_stb : osc_stb;
      end
      tpg_pkg::TPG_TIMING_INTERNAL: begin
        use_internal = 1'b1;
        pix_en = clk_present_reg ? i_pix_stb : osc_stb;
      end
      tpg_pkg::TPG_TIMING_INT_EXTCLK: begin
        use_internal = 1'b1;
        pix_en = ext_stb;
      end
      default: begin
        use_internal = 1'b1;
        pix_en = osc_stb;
      end
    endcase
    pix_en = pix_en & ~pd_s;
  end

  // ==========================================================
  // Timing, coordinates and measurement
  logic [CW-1:0] h_reg, h_next, v_reg, v_next, x_reg, x_next, y_reg, y_next;
  logic [CW-1:0] width_next, height_next, seg_reg, seg_next;
  logic [CW:0] blank_reg, blank_next;
  logic [2:0] band_reg, band_next;
  logic de_prev_reg, de_prev_next, vs_prev_reg, vs_prev_next;
  logic vs_seen_reg, vs_seen_next, frame_end;
  logic t_de, t_hs, t_vs;
  logic [CW-1:0] scale_w, scale_h;

  always_comb begin
    h_next = h_reg;
    v_next = v_reg;
    if (pix_en) begin
      if (h_reg >= h_tot - 1'b1) begin
        h_next = '0;
        v_next = (v_reg >= v_tot - 1'b1) ? '0 : v_reg + 1'b1;
      end else begin
        h_next = h_reg + 1'b1;
      end
    end
    if (use_internal) begin
      t_de = (h_reg < h_act) && (v_reg < v_act);
      t_hs = h_reg >= h_tot - CW'(bank_reg[tpg_pkg::IND_HSYNC_W]);
      t_vs = v_reg >= v_tot - CW'(bank_reg[tpg_pkg::IND_VSYNC_W]);
    end else begin
      t_de = de_s;
      t_hs = hs_s;
      t_vs = vs_s;
    end
    x_next = x_reg;
    y_next = y_reg;
    seg_next = seg_reg;
    band_next = band_reg;
    blank_next = blank_reg;
    width_next = width_reg;
    height_next = height_reg;
    de_prev_next = de_prev_reg;
    vs_prev_next = vs_prev_reg;
    vs_seen_next = vs_seen_reg;
    frame_end = 1'b0;
    scale_w = use_internal ? h_act : width_reg;
    scale_h = use_internal ? v_act : height_reg;
    if (pix_en) begin
      de_prev_next = t_de;
      vs_prev_next = t_vs;
      if (use_internal) begin
        frame_end = (h_reg >= h_tot - 1'b1) && (v_reg >= v_tot - 1'b1);
      end else begin
        if (t_vs & ~vs_prev_reg) begin
          vs_seen_next = 1'b1;
        end
        // Long blank stands in for frame sync
        frame_end = vs_seen_reg ? (t_vs & ~vs_prev_reg)
                                : (blank_reg == {width_reg, 1'b0} + 1'b1);
      end
      if (t_de) begin
        x_next = x_reg + 1'b1;
        blank_next = '0;
        if (seg_reg + 1'b1 >= (scale_w >> 3)) begin
          seg_next = '0;
          band_next = band_reg + 3'h1;
        end else begin
          seg_next = seg_reg + 1'b1;
        end
      end else begin
        x_next = '0;
        seg_next = '0;
        band_next = 3'h0;
        if (blank_reg[CW] == 1'b0) begin
          blank_next = blank_reg + 1'b1;
        end
      end
      if (de_prev_reg & ~t_de) begin
        y_next = y_reg + 1'b1;
        width_next = x_reg;
      end
      if (frame_end) begin
        y_next = '0;
        if (y_reg != '0) begin
          height_next = y_reg;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      h_reg <= '0;
      v_reg <= '0;
      x_reg <= '0;
      y_reg <= '0;
      seg_reg <= '0;
      band_reg <= 3'h0;
      blank_reg <= '0;
      width_reg <= '0;
      height_reg <= '0;
      de_prev_reg <= 1'b0;
      vs_prev_reg <= 1'b0;
      vs_seen_reg <= 1'b0;
    end else begin
      h_reg <= h_next;
      v_reg <= v_next;
      x_reg <= x_next;
      y_reg <= y_next;
      seg_reg <= seg_next;
      band_reg <= band_next;
      blank_reg <= blank_next;
      width_reg <= width_next;
      height_reg <= height_next;
      de_prev_reg <= de_prev_next;
      vs_prev_reg <= vs_prev_next;
      vs_seen_reg <= vs_seen_next;
    end
  end

  // ==========================================================
  // Auto-scroll
  logic [3:0] slot_reg, slot_next;
  logic [7:0] frames_reg, frames_next;
  logic [7:0] slot_byte;
  logic [3:0] slot_entry;
  always_comb begin
    slot_next = slot_reg;
    frames_next = frames_reg;
    if (frame_end && cfg_reg[tpg_pkg::CFG_SCROLL_BIT]) begin
      if (frames_reg + 8'h01 >= bank_reg[tpg_pkg::IND_SCROLL_FRAMES]) begin
        frames_next = 8'h00;
        slot_next = (slot_reg >= bank_reg[tpg_pkg::IND_SCROLL_CTRL][3:0]) ? 4'h0
                                                                         : slot_reg + 4'h1;
      end else begin
        frames_next = frames_reg + 8'h01;
      end
    end
    slot_byte = bank_reg[tpg_pkg::IND_ORDER_FIRST + 32'(slot_reg[3:1])];
    slot_entry = slot_reg[0] ? slot_byte[7:4] : slot_byte[3:0];
    pattern = cfg_reg[tpg_pkg::CFG_SCROLL_BIT] ? {1'b0, slot_entry} + 5'h01
                                               : sel_reg[tpg_pkg::SEL_PATTERN_LSB +:
                                                         tpg_pkg::SEL_PATTERN_W];
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_reg <= 4'h0;
      frames_reg <= 8'h00;
    end else begin
      slot_reg <= slot_next;
      frames_reg <= frames_next;
    end
  end

  // ==========================================================
  // Pattern colour and two-stage output
  logic [23:0] colour, hold_rgb_reg, hold_rgb_next, out_rgb_next;
  logic [7:0] h_lvl, v_lvl, px_mask;
  logic [2:0] hold_sync_reg, hold_sync_next;
  logic [26:0] out_reg, out_next;
  always_comb begin
    h_lvl = 8'(x_reg >> ramp_shift(scale_w));
    v_lvl = 8'(y_reg >> ramp_shift(scale_h));
    unique case (pattern)
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
        colour = (pattern == 5'h02) ? 24'h000000
               : prim(group_mask(2'(pattern - 5'h02 + {4'h0, pattern == tpg_pkg::PAT_WHITE})),
                      8'hFF);
      end
      5'h06, 5'h07, 5'h08, 5'h09: colour = prim(group_mask(2'(pattern - tpg_pkg::PAT_HRAMP_FIRST)),
                                              h_lvl);
      5'h0A, 5'h0B, 5'h0C, 5'h0D: colour = prim(group_mask(2'(pattern - tpg_pkg::PAT_VRAMP_FIRST)),
                                              v_lvl);
      tpg_pkg::PAT_CUSTOM: colour = {bank_reg[tpg_pkg::IND_RED], bank_reg[tpg_pkg::IND_GREEN],
                                     bank_reg[tpg_pkg::IND_BLUE]};
      tpg_pkg::PAT_CHECKER: begin
        if (x_reg[tpg_pkg::CHECKER_BIT] ^ y_reg[tpg_pkg::CHECKER_BIT]) begin
          colour = 24'h000000;
        end else if (sel_reg[tpg_pkg::SEL_CHECKER_CUSTOM_BIT]) begin
          colour = {bank_reg[tpg_pkg::IND_RED], bank_reg[tpg_pkg::IND_GREEN],
                    bank_reg[tpg_pkg::IND_BLUE]};
        end else begin
          colour = 24'hFFFFFF;
        end
      end
      // Yellow, cyan, blue, red or reversed
      tpg_pkg::PAT_FOUR_COLOUR: begin
        unique case (band_reg[2:1] ^ {2{sel_reg[tpg_pkg::SEL_ORDER_REVERSE_BIT]}})
          2'h0: colour = 24'hFFFF00;
          2'h1: colour = 24'h00FFFF;
          2'h2: colour = 24'h0000FF;
          2'h3: colour = 24'hFF0000;
        endcase
      end
      tpg_pkg::PAT_BARS: colour = prim(~{band_reg[1], band_reg[2], band_reg[0]}, 8'hFF);
      default: colour = 24'h000000;
    endcase
    if (sel_reg[tpg_pkg::SEL_INVERT_BIT] ^ cfg_reg[tpg_pkg::CFG_GLOBAL_INVERT_BIT]) begin
      colour = ~colour;
    end
    // Full eight bits unless 18-bit mode
    px_mask = cfg_reg[tpg_pkg::CFG_COLOR18_BIT] ? tpg_pkg::COLOR18_MASK : 8'hFF;
    colour = colour & {3{px_mask}};
    hold_rgb_next = hold_rgb_reg;
    hold_sync_next = hold_sync_reg;
    out_next = out_reg;
    out_rgb_next = hold_rgb_reg;
    // Two pixel clocks from input to output
    if (pix_en) begin
      hold_sync_next = {t_de, t_hs, t_vs};
      hold_rgb_next = cfg_reg[tpg_pkg::CFG_ENABLE_BIT] ? colour : rgb_s;
      out_next = {hold_sync_reg, out_rgb_next};
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_rgb_reg <= 24'h000000;
      hold_sync_reg <= 3'h0;
      out_reg <= '0;
    end else begin
      hold_rgb_reg <= hold_rgb_next;
      hold_sync_reg <= hold_sync_next;
      out_reg <= out_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign {o_de, o_hs, o_vs, o_red, o_green, o_blue} = out_reg;

endmodule

// file: tpg_top_asserts.sv
module tpg_top_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_power_down,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_de,
  input wire logic [7:0] o_red,
  input wire logic [7:0] o_green,
  input wire logic [7:0] o_blue
);
  logic [7:0] cfg_reg, cfg_next, sel_reg, sel_next, age_reg, age_next, low_reg, low_next;
  logic [7:0] mask;
  logic live;
  // ==========================================================
  // Shadow state
  always_comb begin
    cfg_next = cfg_reg;
    sel_next = sel_reg;
    if (i_reg_wr && i_reg_addr == tpg_pkg::REG_CONFIG) cfg_next = i_reg_wdata;
    if (i_reg_wr && i_reg_addr == tpg_pkg::REG_SELECT_CONTROL) sel_next = i_reg_wdata;
    age_next = i_reg_wr ? 8'h00 : age_reg + {7'h00, age_reg != 8'hFF};
    low_next = o_de ? 8'h00 : low_reg + {7'h00, low_reg != 8'hFF};
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= tpg_pkg::CONFIG_RESET;
      sel_reg <= tpg_pkg::SELECT_CONTROL_RESET;
      age_reg <= 8'h00;
      low_reg <= 8'h00;
    end else begin
      cfg_reg <= cfg_next;
      sel_reg <= sel_next;
      age_reg <= age_next;
      low_reg <= low_next;
    end
  end
  // Settling spans 120 clocks, more than one short frame, since a pattern may switch at frame start
  // Auto-scroll overrides the static selection, so pattern checks stand down then
  assign live = cfg_reg[0] && !cfg_reg[5] && age_reg > 8'h78 && !i_power_down;
  assign mask = cfg_reg[2] ? tpg_pkg::COLOR18_MASK : 8'hFF;
  // ==========================================================
  // Properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (i_reg_rd && (i_reg_addr < 8'h64 || i_reg_addr > 8'h67)
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  config_readback_a: assert property (i_reg_rd && i_reg_addr == tpg_pkg::REG_CONFIG
    |=> o_reg_rdata == $past(cfg_reg)) else $error("config readback");
  select_readback_a: assert property (i_reg_rd && i_reg_addr == tpg_pkg::REG_SELECT_CONTROL
    |=> o_reg_rdata == $past(sel_reg)) else $error("select readback");
  frame_alive_a: assert property (live && cfg_reg[4:3] == 2'b01 |-> low_reg < 8'h64)
    else $error("internal frame stalled");
  solid_level_a: assert property (live && o_de && sel_reg[4:0] == 5'h01 |->
    {o_red, o_green, o_blue} == ((sel_reg[5] ^ cfg_reg[1]) ? 24'h0 : {3{mask}}))
    else $error("solid level wrong");
  low_bits_a: assert property (live && o_de && cfg_reg[2] |->
    {o_red[1:0], o_green[1:0], o_blue[1:0]} == 6'h00) else $error("low bits set");
  checker_bw_a: assert property (live && o_de && sel_reg[6:0] == 7'h0F |->
    o_red == o_green && o_green == o_blue && (o_red == 8'h00 || o_red == mask))
    else $error("checker colour wrong");
  cover property (live && o_de && sel_reg[4:0] == 5'h01);
  cover property (live && $rose(o_de));
  cover property (i_reg_rd && i_reg_addr == tpg_pkg::REG_INDIRECT_DATA);
endmodule
bind tpg_top tpg_top_checker tpg_top_checker_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_power_down(i_power_down), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_de(o_de), .o_red(o_red), .o_green(o_green), .o_blue(o_blue));

// file: tpg_panel_model.sv
module tpg_panel_model (
  input wire logic i_sys_clk,
  input wire logic i_de,
  input wire logic [23:0] i_pixel,
  output logic [23:0] o_last_pixel,
  output logic [7:0] o_line_width
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run = 8'h00;
  // Panel keeps the last shown pixel; width is the last complete line
  always @(posedge i_sys_clk) begin
    run <= i_de ? run + 8'h01 : 8'h00;
    if (i_de) o_last_pixel <= i_pixel;
    if (!i_de && run != 8'h00) o_line_width <= run;
  end
endmodule

// file: tpg_top_tb.sv
module tpg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_de = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] i_red = 8'h00;
  logic pix_stb = 1'b1;
  logic pd = 1'b0;
  logic ext_clk = 1'b0;
  logic [7:0] o_reg_rdata, o_red, o_green, o_blue, line_width;
  logic o_de;
  logic [23:0] last_pixel;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  // Short raster so a frame lasts 72 clocks
  localparam logic [7:0] TIMING [11] = '{8'h08, 8'h00, 8'h0C, 8'h00, 8'h04, 8'h00,
    8'h06, 8'h00, 8'h02, 8'h01, 8'h00};
  localparam logic [23:0] SOLID [5] = '{24'hFFFFFF, 24'h000000, 24'hFF0000, 24'h00FF00,
    24'h0000FF};
  tpg_top tpg_top_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_power_down(pd),
    .i_pix_stb(pix_stb), .i_ext_clk(ext_clk), .i_de(i_de), .i_hs(1'b0), .i_vs(1'b0),
    .i_red(i_red), .i_green(i_red), .i_blue(i_red), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_de(o_de), .o_hs(), .o_vs(), .o_red(o_red),
    .o_green(o_green), .o_blue(o_blue));
  tpg_panel_model tpg_panel_model_i (.i_sys_clk(i_sys_clk), .i_de(o_de),
    .i_pixel({o_red, o_green, o_blue}), .o_last_pixel(last_pixel), .o_line_width(line_width));
  // ==========================================================
  // Clock and watchdog
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // External pixel clock at half the system rate
  always @(negedge i_sys_clk) begin
    ext_clk <= ~ext_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ==========================================================
  // Access tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_sys_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    @(negedge i_sys_clk);
    chk({16'h0, o_reg_rdata}, {16'h0, e});
  endtask
  task automatic ind(input logic [7:0] idx, input logic [7:0] d);
    wr(tpg_pkg::REG_INDIRECT_ADDRESS, idx);
    wr(tpg_pkg::REG_INDIRECT_DATA, d);
  endtask
  task automatic show(input logic [7:0] sel, input logic [7:0] cfg, input logic [23:0] e);
    int gap;
    gap = 0;
    wr(tpg_pkg::REG_SELECT_CONTROL, sel);
    wr(tpg_pkg::REG_CONFIG, cfg);
    repeat (200) @(negedge i_sys_clk);
    // Compare at a frame's last pixel, found after a long gap in active video
    while (o_de || gap < 20) begin
      @(negedge i_sys_clk);
      gap = o_de ? 0 : gap + 1;
    end
    chk(last_pixel, e);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    rd(tpg_pkg::REG_SELECT_CONTROL, tpg_pkg::SELECT_CONTROL_RESET);
    rd(tpg_pkg::REG_CONFIG, tpg_pkg::CONFIG_RESET);
    rd(8'h20, 8'h00);
    ind(8'h03, 8'h0B);
    rd(tpg_pkg::REG_INDIRECT_DATA, 8'h0B);
    i_de = 1'b1;
    i_red = 8'h5A;
    repeat (12) @(negedge i_sys_clk);
    chk({15'h0, o_de, o_red}, 24'h00015A);
    i_de = 1'b0;
    wr(tpg_pkg::REG_INDIRECT_ADDRESS, tpg_pkg::IND_WIDTH_LO);
    rd(tpg_pkg::REG_INDIRECT_DATA, 8'h0C);
    repeat (30) @(negedge i_sys_clk);
    wr(tpg_pkg::REG_INDIRECT_ADDRESS, tpg_pkg::IND_HEIGHT_LO);
    rd(tpg_pkg::REG_INDIRECT_DATA, 8'h01);
    for (int k = 0; k < 11; k++) ind(8'(13 + k), TIMING[k]);
    ind(8'h00, 8'h57);
    ind(8'h01, 8'hA3);
    ind(8'h02, 8'hFF);
    for (int k = 0; k < 10; k++) begin
      show({2'b00, k[0], 5'(k / 2 + 1)}, 8'h09, k[0] ? ~SOLID[k / 2] : SOLID[k / 2]);
    end
    chk({16'h0, line_width}, 24'h000008);
    show(8'h03, 8'h0B, 24'h00FFFF);
    show(8'h0E, 8'h0D, 24'h54A0FC);
    show(8'h0F, 8'h0D, 24'hFCFCFC);
    show(8'h4F, 8'h0D, 24'h54A0FC);
    show(8'h06, 8'h09, 24'h070707);
    show(8'h0A, 8'h09, 24'h030303);
    show(8'h10, 8'h09, 24'hFF0000);
    show(8'h90, 8'h09, 24'hFFFF00);
    show(8'h11, 8'h09, 24'h000000);
    ind(8'h03, 8'h01);
    ind(8'h04, 8'h01);
    ind(8'h05, 8'h22);
    show(8'h01, 8'h29, 24'hFF0000);
    pix_stb = 1'b0;
    show(8'h04, 8'h09, 24'h00FF00);
    wr(tpg_pkg::REG_INDIRECT_ADDRESS, tpg_pkg::IND_STATUS);
    rd(tpg_pkg::REG_INDIRECT_DATA, 8'h04);
    pix_stb = 1'b1;
    show(8'h05, 8'h11, 24'h0000FF);
    pd = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    wr(tpg_pkg::REG_SELECT_CONTROL, 8'h03);
    repeat (50) @(negedge i_sys_clk);
    chk({o_red, o_green, o_blue}, 24'h0000FF);
    pd = 1'b0;
    show(8'h03, 8'h11, 24'hFF0000);
    wrap_up();
  end
endmodule
